/* File: shared/ncsr_params.svh */
// Purpose: Offsets, field positions, reset values and timing counts for the CSR group
// Assumes: 100 MHz sys_clk
// Notes:   Definitions only
`ifndef NCSR_PARAMS_SVH
`define NCSR_PARAMS_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define NCSR_OFF_RXDP      8'h98
`define NCSR_OFF_TXBR      8'h9C
`define NCSR_OFF_FLASH     8'hA0
`define NCSR_OFF_STA_LO    8'hA4
`define NCSR_OFF_STA_HI    8'hA8
`define NCSR_OFF_GRP_LO    8'hAC
`define NCSR_OFF_GRP_HI    8'hB0
`define NCSR_OFF_UNI_LO    8'hB4
`define NCSR_OFF_UNI_HI    8'hB8
`define NCSR_OFF_IRQ_STAT  8'hC0
`define NCSR_OFF_IRQ_MASK  8'hC4
// ****************************************
// Field positions and reset values
// ****************************************
`define NCSR_BURST_MSB     20
`define NCSR_BURST_LSB     16
`define NCSR_TTO_MSB       11
`define NCSR_LED_BIT       31
`define NCSR_REN_BIT       27
`define NCSR_WEN_BIT       26
`define NCSR_FADDR_MSB     25
`define NCSR_FADDR_LSB     8
`define NCSR_FLASH_RST     32'h80000000
`define NCSR_ZERO32        32'h00000000
`define NCSR_RX_STOPPED    3'h0
`define NCSR_STA_HI_MASK   32'h0000FFFF
`define NCSR_TXBR_MASK     32'h001F0FFF
`define NCSR_FLASH_MASK    32'h8FFFFFFF
// ****************************************
// Timing: tick periods in ns and cycles, flash strobe length, irq bit positions
// ****************************************
`define NCSR_CLK_NS        10
`define NCSR_TICK100_NS    2560
`define NCSR_TICK10_NS     25600
`define NCSR_TICK100_CYC   (`NCSR_TICK100_NS / `NCSR_CLK_NS)
`define NCSR_TICK10_CYC    (`NCSR_TICK10_NS / `NCSR_CLK_NS)
`define NCSR_FLASH_CYC     4
`define NCSR_IRQ_TXDONE    0
`define NCSR_IRQ_TXDEF     1
`define NCSR_IRQ_FLASH     2
`endif

/* File: shared/ncsr_pkg.sv */
// Purpose: Types shared by the CSR group modules
// Assumes: Used with ncsr_params.svh
// Notes:   Packed carriers for the register bus and flash pins
package ncsr_pkg;
  // Register bus request
  typedef struct packed {
    logic [7:0]  addr;  // Byte address
    logic [31:0] wdata; // Write data
    logic        wr;    // Write strobe
    logic        rd;    // Read strobe
  } ncsr_bus_t;
  // Flash boot ROM pins
  typedef struct packed {
    logic [17:0] addr;  // Byte address
    logic [7:0]  dout;  // Write data
    logic        dout_oe; // Drive data pins
    logic        ce_n;  // Chip enable
    logic        oe_n;  // Output enable
    logic        we_n;  // Write enable
  } ncsr_flash_t;
  // Flash port states
  typedef enum logic [1:0] {
    NCSR_FL_IDLE,
    NCSR_FL_READ,
    NCSR_FL_WRITE
  } ncsr_fl_state_t;
endpackage : ncsr_pkg

/* File: src/ncsr_tx_timer.sv */
// Purpose: Transmit burst counter and transmit time-out timer
// Assumes: Event inputs are one-cycle pulses on sys_clk
// Notes:   Tick rate follows the link speed
`timescale 1ns/1ps
`include "ncsr_params.svh"
module ncsr_tx_timer
  import ncsr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [4:0]  burst_target,   // Burst count field
  input  wire logic [11:0] timeout_value,  // Timer reload value
  input  wire logic        timeout_load,   // Software wrote the timer
  input  wire logic        defer_en,       // Deferred irq enable
  input  wire logic        speed_100,      // 1 = 100 Mb/s
  input  wire logic        tx_ok,          // Successful transmit pulse
  input  wire logic        tx_start,       // Transmit start pulse
  output logic      [11:0] timer_now,      // Current timer value
  output logic             burst_done,     // Burst reached pulse
  output logic             defer_expired   // Timer expiry pulse
);
  // ****************************************
  // State
  // ****************************************
  logic [4:0]  burst_ff;     // Successes since the last burst
  logic [11:0] timer_ff;     // Down counter
  logic [11:0] tick_ff;      // Tick prescaler
  logic        armed_ff;     // Timer running toward expiry
  logic [4:0]  nxt_burst;
  logic [11:0] tick_max;
  logic        tick;
  wire         burst_hit = tx_ok && (nxt_burst == burst_target);
  assign nxt_burst = burst_ff + 5'h01;
  assign tick_max  = speed_100 ? 12'(`NCSR_TICK100_CYC - 1) : 12'(`NCSR_TICK10_CYC - 1);
  assign tick      = (tick_ff == tick_max);
  assign timer_now = timer_ff;

  // RULE_01 burst count wrap
  // Zero target never fires, which keeps a cleared field harmless
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      burst_ff   <= 5'h00;
      burst_done <= 1'b0;
    end else begin
      burst_done <= burst_hit && (burst_target != 5'h00);
      if (burst_hit)
        burst_ff <= 5'h00;
      else if (tx_ok)
        burst_ff <= nxt_burst;
    end
  end

  // Prescaler free-runs so speed changes take effect at once
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      tick_ff <= 12'h000;
    else if (tick || tick_ff > tick_max)
      tick_ff <= 12'h000;
    else
      tick_ff <= tick_ff + 12'h001;
  end

  // RULE_02 timed decrement
  // RULE_03 expiry before start
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_ff      <= 12'h000;
      armed_ff      <= 1'b0;
      defer_expired <= 1'b0;
    end else begin
      defer_expired <= 1'b0;
      if (timeout_load || tx_start) begin
        timer_ff <= timeout_value;
        armed_ff <= (timeout_value != 12'h000);
      end else if (defer_en && armed_ff && tick) begin
        timer_ff <= timer_ff - 12'h001;
        if (timer_ff == 12'h001) begin
          armed_ff      <= 1'b0;
          defer_expired <= 1'b1;
        end
      end
    end
  end
endmodule : ncsr_tx_timer

/* File: src/ncsr_flash_port.sv */
// Purpose: Byte-wide indirect access sequencer for the boot flash
// Assumes: Flash answers within the fixed strobe window
// Notes:   One access at a time; read wins if both enables set
`timescale 1ns/1ps
`include "ncsr_params.svh"
module ncsr_flash_port
  import ncsr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        rd_go,       // Read requested
  input  wire logic        wr_go,       // Write requested
  input  wire logic [17:0] addr,        // Byte address
  input  wire logic [7:0]  wdata,       // Byte to write
  input  wire logic        bit16_share, // Route LED level onto addr bit 16
  input  wire logic        led_active,  // Duplex/collision LED level
  input  wire logic [7:0]  flash_din,   // Flash data pins, synchronised
  output ncsr_flash_t      pins,        // Flash pins
  output logic             rd_done,     // Read byte ready pulse
  output logic             wr_done,     // Write finished pulse
  output logic      [7:0]  rd_byte      // Byte read
);
  // ****************************************
  // Sequencer
  // ****************************************
  ncsr_fl_state_t state_ff;
  logic [2:0]     cnt_ff;     // Strobe width counter
  wire            last = (cnt_ff == 3'(`NCSR_FLASH_CYC - 1));

  // RULE_07 shared address bit
  // LED path owns bit 16 whenever sharing is on, accesses included
  always_comb begin
    pins.addr    = addr;
    if (bit16_share)
      pins.addr[16] = led_active;
    pins.dout    = wdata;
    pins.dout_oe = (state_ff == NCSR_FL_WRITE);
    pins.ce_n    = (state_ff == NCSR_FL_IDLE);
    pins.oe_n    = (state_ff != NCSR_FL_READ);
    pins.we_n    = (state_ff != NCSR_FL_WRITE);
  end

  // RULE_04 read sequence
  // RULE_05 write sequence
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= NCSR_FL_IDLE;
      cnt_ff   <= 3'h0;
      rd_done  <= 1'b0;
      wr_done  <= 1'b0;
      rd_byte  <= 8'h00;
    end else begin
      rd_done <= 1'b0;
      wr_done <= 1'b0;
      case (state_ff)
        NCSR_FL_IDLE: begin
          cnt_ff <= 3'h0;
          if (rd_go)
            state_ff <= NCSR_FL_READ;
          else if (wr_go)
            state_ff <= NCSR_FL_WRITE;
        end
        NCSR_FL_READ: begin
          cnt_ff <= cnt_ff + 3'h1;
          if (last) begin
            rd_byte  <= flash_din;
            rd_done  <= 1'b1;
            state_ff <= NCSR_FL_IDLE;
          end
        end
        NCSR_FL_WRITE: begin
          cnt_ff <= cnt_ff + 3'h1;
          if (last) begin
            wr_done  <= 1'b1;
            state_ff <= NCSR_FL_IDLE;
          end
        end
        default: state_ff <= NCSR_FL_IDLE;
      endcase
    end
  end
endmodule : ncsr_flash_port

/* File: src/ncsr_top.sv */
// Purpose: CSR group: descriptor pointer, tx burst/time-out, flash port, address filters
// Assumes: Simple strobe bus on sys_clk; MAC event pulses on sys_clk
// Notes:   Flash data pins pass two flops before use; other inputs are used unsynchronised
`timescale 1ns/1ps
`include "ncsr_params.svh"
// Functional notes
// RULE_01 - Burst count of successes raises tx-done irq
// RULE_02 - Time-out timer ticks 2.56/25.6 us when enabled
// RULE_03 - Timer expiry before next start: deferred irq
// RULE_04 - Read enable fetches byte, then self-clears
// RULE_05 - Write enable writes byte, clears when done
// RULE_06 - Flash address 25:8, data 7:0, both RW
// RULE_07 - Bit 31 low shares ROM bit16 with LED
// RULE_08 - Station bytes packed little-endian over two words
// RULE_09 - Station address loaded from serial EEPROM
// RULE_10 - Station writes only while receive stopped
// RULE_11 - Group hash writes only while receive stopped
// RULE_12 - Group hash: high word is bits 63:32
// RULE_13 - Unicast hash: low word is bits 31:0
// RULE_14 - Unicast lookup uses same hash as multicast
// RULE_15 - Receive descriptor pointer readable, read-only
// RULE_16 - Blocked address writes ignored, bus completes
// RULE_17 - Six-bit index; set table bit accepts
module ncsr_top
  import ncsr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // Register bus
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // MAC and DMA side
  input  wire logic [31:0] rx_desc_ptr_now,
  input  wire logic [2:0]  rx_state,
  input  wire logic        tx_ok,
  input  wire logic        tx_start,
  input  wire logic        tx_deferred_irq_enable,
  input  wire logic        speed_100,
  input  wire logic        led_scheme_select,
  input  wire logic        fd_col_led,
  // Serial EEPROM loader
  input  wire logic        ee_load,
  input  wire logic [47:0] ee_station,
  // Hash lookup
  input  wire logic [5:0]  hash_index,
  input  wire logic        hash_is_group,
  output logic             hash_accept,
  // Flash pins
  input  wire logic [7:0]  flash_din,
  output logic      [17:0] flash_addr,
  output logic      [7:0]  flash_dout,
  output logic             flash_dout_oe,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  // Interrupt
  output logic             irq
);
  // ****************************************
  // Register storage
  // ****************************************
  logic [31:0] txbr_ff;        // Burst count and time-out fields
  logic [31:0] flash_ff;       // Flash port register
  logic [31:0] sta_lo_ff;      // Station bytes 0..3
  logic [15:0] sta_hi_ff;      // Station bytes 4..5
  logic [63:0] grp_hash_ff;    // Group hash table
  logic [63:0] uni_hash_ff;    // Unicast hash table
  logic [2:0]  irq_stat_ff;    // Sticky events
  logic [2:0]  irq_mask_ff;    // Event mask
  logic [7:0]  fdin_s1_ff;     // Flash data sync stage 1
  logic [7:0]  fdin_s2_ff;     // Flash data sync stage 2
  logic [11:0] timer_now;
  logic        burst_done;
  logic        defer_expired;
  logic        rd_done;
  logic        wr_done;
  logic [7:0]  rd_byte;
  ncsr_flash_t fpins;

  // ****************************************
  // Address decode
  // ****************************************
  wire hit_txbr  = (reg_addr == `NCSR_OFF_TXBR);
  wire hit_flash = (reg_addr == `NCSR_OFF_FLASH);
  wire hit_stalo = (reg_addr == `NCSR_OFF_STA_LO);
  wire hit_stahi = (reg_addr == `NCSR_OFF_STA_HI);
  wire hit_grplo = (reg_addr == `NCSR_OFF_GRP_LO);
  wire hit_grphi = (reg_addr == `NCSR_OFF_GRP_HI);
  wire hit_unilo = (reg_addr == `NCSR_OFF_UNI_LO);
  wire hit_unihi = (reg_addr == `NCSR_OFF_UNI_HI);
  wire hit_stat  = (reg_addr == `NCSR_OFF_IRQ_STAT);
  wire hit_mask  = (reg_addr == `NCSR_OFF_IRQ_MASK);
  // RULE_10 stopped gate
  // RULE_11 stopped gate
  wire rx_stopped = (rx_state == `NCSR_RX_STOPPED);
  // RULE_16 blocked writes dropped
  // The bus still completes; nothing else signals the drop
  wire addr_wr    = reg_wr && rx_stopped;
  wire stat_rd    = reg_rd && hit_stat;
  wire flash_busy = flash_ff[`NCSR_REN_BIT] || flash_ff[`NCSR_WEN_BIT];

  // ****************************************
  // Flash data synchroniser
  // ****************************************
  // Data pins are asynchronous to sys_clk
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fdin_s1_ff <= 8'h00;
      fdin_s2_ff <= 8'h00;
    end else begin
      fdin_s1_ff <= flash_din;
      fdin_s2_ff <= fdin_s1_ff;
    end
  end

  // ****************************************
  // Transmit burst / time-out register
  // ****************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      txbr_ff <= `NCSR_ZERO32;
    else if (reg_wr && hit_txbr)
      txbr_ff <= reg_wdata & `NCSR_TXBR_MASK;
  end

  ncsr_tx_timer u_tx_timer (
    .sys_clk       (sys_clk),
    .arst_n        (arst_n),
    .burst_target  (txbr_ff[`NCSR_BURST_MSB:`NCSR_BURST_LSB]),
    .timeout_value (txbr_ff[`NCSR_TTO_MSB:0]),
    .timeout_load  (reg_wr && hit_txbr),
    .defer_en      (tx_deferred_irq_enable),
    .speed_100     (speed_100),
    .tx_ok         (tx_ok),
    .tx_start      (tx_start),
    .timer_now     (timer_now),
    .burst_done    (burst_done),
    .defer_expired (defer_expired)
  );

  // ****************************************
  // Flash port register
  // ****************************************
  // RULE_06 address and data fields
  // Writes while an access runs are ignored to keep the strobes clean
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_ff <= `NCSR_FLASH_RST;
    end else if (reg_wr && hit_flash && !flash_busy) begin
      flash_ff <= reg_wdata & `NCSR_FLASH_MASK;
    end else begin
      // RULE_04 read data and self-clear
      if (rd_done) begin
        flash_ff[7:0]           <= rd_byte;
        flash_ff[`NCSR_REN_BIT] <= 1'b0;
      end
      // RULE_05 clear on completion
      if (wr_done)
        flash_ff[`NCSR_WEN_BIT] <= 1'b0;
    end
  end

  ncsr_flash_port u_flash_port (
    .sys_clk     (sys_clk),
    .arst_n      (arst_n),
    .rd_go       (flash_ff[`NCSR_REN_BIT]),
    .wr_go       (flash_ff[`NCSR_WEN_BIT] && !flash_ff[`NCSR_REN_BIT]),
    .addr        (flash_ff[`NCSR_FADDR_MSB:`NCSR_FADDR_LSB]),
    .wdata       (flash_ff[7:0]),
    // RULE_07 four-LED scheme only
    .bit16_share (led_scheme_select && !flash_ff[`NCSR_LED_BIT]),
    .led_active  (fd_col_led),
    .flash_din   (fdin_s2_ff),
    .pins        (fpins),
    .rd_done     (rd_done),
    .wr_done     (wr_done),
    .rd_byte     (rd_byte)
  );

  assign flash_addr    = fpins.addr;
  assign flash_dout    = fpins.dout;
  assign flash_dout_oe = fpins.dout_oe;
  assign flash_ce_n    = fpins.ce_n;
  assign flash_oe_n    = fpins.oe_n;
  assign flash_we_n    = fpins.we_n;

  // ****************************************
  // Station address
  // ****************************************
  // RULE_09 EEPROM load
  // RULE_08 byte packing
  // Loader wins over a host write in the same cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sta_lo_ff <= `NCSR_ZERO32;
      sta_hi_ff <= 16'h0000;
    end else if (ee_load) begin
      sta_lo_ff <= ee_station[31:0];
      sta_hi_ff <= ee_station[47:32];
    end else if (addr_wr && hit_stalo) begin
      sta_lo_ff <= reg_wdata;
    end else if (addr_wr && hit_stahi) begin
      sta_hi_ff <= reg_wdata[15:0];
    end
  end

  // ****************************************
  // Hash tables
  // ****************************************
  // RULE_12 group table halves
  // RULE_13 unicast table halves
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      grp_hash_ff <= {`NCSR_ZERO32, `NCSR_ZERO32};
      uni_hash_ff <= {`NCSR_ZERO32, `NCSR_ZERO32};
    end else begin
      if (addr_wr && hit_grplo)
        grp_hash_ff[31:0] <= reg_wdata;
      if (addr_wr && hit_grphi)
        grp_hash_ff[63:32] <= reg_wdata;
      if (addr_wr && hit_unilo)
        uni_hash_ff[31:0] <= reg_wdata;
      if (addr_wr && hit_unihi)
        uni_hash_ff[63:32] <= reg_wdata;
    end
  end

  // RULE_14 one shared index
  // RULE_17 set bit accepts
  // Index comes from the MAC's hash, the same for both tables
  assign hash_accept = hash_is_group ? grp_hash_ff[hash_index] : uni_hash_ff[hash_index];

  // ****************************************
  // Interrupts
  // ****************************************
  // Set wins over the read-clear in the same cycle
  logic [2:0] irq_set;
  assign irq_set = {wr_done || rd_done, defer_expired, burst_done};
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_ff <= 3'h0;
      irq_mask_ff <= 3'h0;
    end else begin
      irq_stat_ff <= (stat_rd ? 3'h0 : irq_stat_ff) | irq_set;
      if (reg_wr && hit_mask)
        irq_mask_ff <= reg_wdata[2:0];
    end
  end
  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ****************************************
  // Read mux
  // ****************************************
  logic [31:0] rd_mux;
  always_comb begin
    // RULE_15 live pointer
    if (reg_addr == `NCSR_OFF_RXDP)
      rd_mux = rx_desc_ptr_now;
    else if (hit_txbr)
      rd_mux = {txbr_ff[31:12], timer_now};
    else if (hit_flash)
      rd_mux = flash_ff;
    else if (hit_stalo)
      rd_mux = sta_lo_ff;
    else if (hit_stahi)
      rd_mux = {16'h0000, sta_hi_ff};
    else if (hit_grplo)
      rd_mux = grp_hash_ff[31:0];
    else if (hit_grphi)
      rd_mux = grp_hash_ff[63:32];
    else if (hit_unilo)
      rd_mux = uni_hash_ff[31:0];
    else if (hit_unihi)
      rd_mux = uni_hash_ff[63:32];
    else if (hit_stat)
      rd_mux = {29'h0, irq_stat_ff};
    else if (hit_mask)
      rd_mux = {29'h0, irq_mask_ff};
    else
      rd_mux = `NCSR_ZERO32;
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      reg_rdata <= `NCSR_ZERO32;
    else if (reg_rd)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= `NCSR_ZERO32;
  end
endmodule : ncsr_top

/* File: sim/ncsr_top_asserts.sv */
// Purpose: Port assertions for the CSR group
// Assumes: One clock domain, sys_clk
// Notes:   Sees only top-level ports
`timescale 1ns/1ps
module ncsr_top_asserts (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [31:0] rx_desc_ptr_now,
  input wire logic [17:0] flash_addr,
  input wire logic        flash_dout_oe,
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_we_n
);
  // Single domain, reset gates all
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Strobe phases of one flash access
  sequence rd_phase; !flash_ce_n && !flash_oe_n && flash_we_n; endsequence
  sequence wr_phase; !flash_ce_n && !flash_we_n && flash_dout_oe; endsequence
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data set outside a read");
  unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h80 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  rxptr_rd_a: assert property (reg_rd && reg_addr == 8'h98 |=>
    reg_rdata == $past(rx_desc_ptr_now)) else $error("pointer read wrong");
  rd_strobe_a: assert property ($fell(flash_oe_n) |-> rd_phase [*4] ##1 flash_oe_n)
    else $error("read strobe length");
  wr_strobe_a: assert property ($fell(flash_we_n) |-> wr_phase [*4] ##1 flash_we_n)
    else $error("write strobe length");
  idle_pins_a: assert property (flash_ce_n |-> flash_oe_n && flash_we_n && !flash_dout_oe)
    else $error("strobe without chip enable");
  drive_we_a: assert property (flash_dout_oe |-> !flash_we_n)
    else $error("data driven outside write");
  addr_hold_a: assert property (!flash_ce_n && !$past(flash_ce_n) |->
    $stable({flash_addr[17], flash_addr[15:0]})) else $error("address moved in strobe");
endmodule : ncsr_top_asserts

/* File: sim/ncsr_flash_model.sv */
// Purpose: Boot flash partner for the CSR bench
// Assumes: Byte-wide part driven by ncsr_top strobes
// Notes:   Only 1 KB of the array is modelled
`timescale 1ns/1ps
module ncsr_flash_model #(
  parameter int SLOW = 0  // Strobe cycles before data is valid
) (
  input  wire logic        sys_clk,
  input  wire logic [17:0] flash_addr,
  input  wire logic [7:0]  flash_dout,
  input  wire logic        flash_dout_oe,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_we_n,
  output logic      [7:0]  flash_din
);
  logic [7:0] mem [1024];      // Byte array
  logic [7:0] last_q = 8'h00;  // Last byte shown
  int         age = 0;         // Read strobe age
  wire        rd_sel = !flash_ce_n && !flash_oe_n;
  initial for (int i = 0; i < 1024; i++) mem[i] = 8'(i) ^ 8'h5A;
  // byte on pins
  // Released pins show the inverse, so a stale byte never passes
  assign flash_din = (rd_sel && age >= SLOW) ? mem[flash_addr[9:0]] : ~last_q;
  always @(posedge sys_clk) begin
    age <= rd_sel ? age + 1 : 0;
    if (rd_sel) last_q <= flash_din;
    if (!flash_ce_n && !flash_we_n && flash_dout_oe) mem[flash_addr[9:0]] <= flash_dout;
  end
endmodule : ncsr_flash_model

/* File: sim/ncsr_top_tb_top.sv */
// Purpose: Self-checking bench for ncsr_top
// Assumes: 100 MHz sys_clk, flash model on the pins
// Notes:   Reads are noted in a queue and checked a cycle later
`timescale 1ns/1ps
module ncsr_top_tb_top;
  logic        sys_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, tx_ok = 0, tx_start = 0;
  logic        tx_deferred_irq_enable = 0, speed_100 = 1, led_scheme_select = 0;
  logic        fd_col_led = 0, ee_load = 0, hash_is_group = 0, hash_accept, irq, rd_d = 0;
  logic        flash_dout_oe, flash_ce_n, flash_oe_n, flash_we_n;
  logic [7:0]  reg_addr = '0, flash_din, flash_dout;
  logic [31:0] reg_wdata = '0, reg_rdata, rx_desc_ptr_now = '0, v, tbl [8];
  logic [2:0]  rx_state = '0;
  logic [47:0] ee_station = '0;
  logic [5:0]  hash_index = '0;
  logic [17:0] flash_addr, a;
  logic [63:0] t, e, expq [$];
  logic [15:0] seed = 16'h5AF6;  // LFSR start
  int          failures = 0, total_checks = 0, cycles = 0;
  logic [7:0]  offs [8] = '{8'h9C, 8'hA0, 8'hA4, 8'hA8, 8'hAC, 8'hB0, 8'hB4, 8'hB8};
  ncsr_top i_ncsr_top (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .rx_desc_ptr_now, .rx_state, .tx_ok, .tx_start, .tx_deferred_irq_enable,
    .speed_100, .led_scheme_select, .fd_col_led, .ee_load, .ee_station, .hash_index,
    .hash_is_group, .hash_accept, .flash_din, .flash_addr, .flash_dout, .flash_dout_oe,
    .flash_ce_n, .flash_oe_n, .flash_we_n, .irq);
  ncsr_flash_model #(.SLOW(0)) i_ncsr_flash_model (.sys_clk, .flash_addr, .flash_dout,
    .flash_dout_oe, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_din);
  initial forever #5 sys_clk = ~sys_clk;
  // Hang guard: a stuck run counts as a mismatch
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    rd_d <= reg_rd;
    if (cycles == 40000) begin
      failures++;
      complete_run();
    end
  end
  // Watcher: oldest note against the data now on the bus
  always @(negedge sys_clk) begin
    if (rd_d) begin
      e = expq.pop_front();
      check(reg_rdata & e[63:32], e[31:0] & e[63:32]);
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  // One bus cycle, then a gap so strobes never re-rise in one step
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d, m);
    if (!w) expq.push_back({m, d});
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle
  function automatic logic [31:0] r32();
    logic [15:0] hi;
    hi = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    seed = {hi[14:0], hi[15] ^ hi[13] ^ hi[12] ^ hi[10]};
    return {hi, seed};
  endfunction : r32
  // Flash command, then the address seen on the pins mid-strobe
  task automatic fl(input logic [31:0] c, input logic [17:0] ea);
    int n;
    n = 0;
    bus(1'b1, 8'hA0, c, '0);
    @(negedge sys_clk);
    while (flash_ce_n && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    check({14'h0, flash_addr}, {14'h0, ea});
    idle(12);
  endtask : fl
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  // ************
  // Main sequence
  // ************
  initial begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    foreach (offs[i]) bus(1'b0, offs[i], (i == 1) ? 32'h80000000 : 32'h0, '1);
    bus(1'b1, 8'h80, r32(), '0);
    bus(1'b0, 8'h80, 32'h0, '1);
    v = r32();
    rx_desc_ptr_now <= v;
    bus(1'b1, 8'h98, ~v, '0);
    bus(1'b0, 8'h98, v, '1);
    // Filters accept writes while stopped, drop them in receive states 2 to 7
    for (int i = 2; i < 8; i++) begin
      v = r32();
      tbl[i] = (i == 3) ? {16'h0, v[15:0]} : v;
      bus(1'b1, offs[i], v, '0);
      bus(1'b0, offs[i], tbl[i], '1);
    end
    for (int i = 2; i < 8; i++) begin
      rx_state <= 3'(i);
      bus(1'b1, offs[i], r32(), '0);
      bus(1'b0, offs[i], tbl[i], '1);
    end
    rx_state <= 3'h0;
    for (int i = 0; i < 16; i++) begin
      v = r32();
      t = v[6] ? {tbl[5], tbl[4]} : {tbl[7], tbl[6]};
      hash_index <= v[5:0];
      hash_is_group <= v[6];
      @(negedge sys_clk);
      check({31'h0, hash_accept}, {31'h0, t[v[5:0]]});
      @(posedge sys_clk);
    end
    tbl[0] = r32();
    v = r32();
    ee_station <= {v[15:0], tbl[0]};
    ee_load <= 1'b1;
    @(posedge sys_clk);
    ee_load <= 1'b0;
    bus(1'b0, 8'hA4, tbl[0], '1);
    bus(1'b0, 8'hA8, {16'h0, v[15:0]}, '1);
    // Burst of three: masked first, then raising the line
    bus(1'b1, 8'h9C, 32'h00030000, '0);
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, 8'hC4, {31'h0, k[0]}, '0);
      for (int n = 1; n <= 3; n++) begin
        tx_ok <= 1'b1;
        @(posedge sys_clk);
        tx_ok <= 1'b0;
        idle(3);
        check({31'h0, irq}, {31'h0, k[0] && n == 3});
      end
      bus(1'b0, 8'hC0, 32'h1, 32'h1);
      idle(2);
      check({31'h0, irq}, 32'h0);
    end
    // Deferral timer at both rates, reloaded once by a start
    bus(1'b1, 8'hC4, 32'h2, '0);
    tx_deferred_irq_enable <= 1'b1;
    for (int s = 1; s >= 0; s--) begin
      int tk;
      tk = s ? 256 : 2560;
      speed_100 <= s[0];
      bus(1'b1, 8'h9C, 32'h3, '0);
      idle(2 * tk - 20);
      bus(1'b0, 8'hC0, 32'h0, 32'h2);
      tx_start <= 1'b1;
      @(posedge sys_clk);
      tx_start <= 1'b0;
      idle(2 * tk - 20);
      bus(1'b0, 8'hC0, 32'h0, 32'h2);
      idle(tk + 60);
      check({31'h0, irq}, 32'h1);
      bus(1'b0, 8'hC0, 32'h2, 32'h2);
    end
    // Flash read, write, read back, then bit 16 routing
    bus(1'b1, 8'hC4, 32'h4, '0);
    v = r32();
    a = {v[17], 1'b0, v[15:0]};
    fl({4'h8, 2'b10, a, 8'h00}, a);
    bus(1'b0, 8'hA0, {4'h8, 2'b00, a, a[7:0] ^ 8'h5A}, '1);
    bus(1'b0, 8'hC0, 32'h4, 32'h4);
    fl({4'h8, 2'b01, a, v[31:24]}, a);
    bus(1'b0, 8'hA0, {4'h8, 2'b00, a, v[31:24]}, '1);
    fl({4'h8, 2'b10, a, 8'h00}, a);
    bus(1'b0, 8'hA0, {4'h8, 2'b00, a, v[31:24]}, '1);
    fd_col_led <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      led_scheme_select <= k[0];
      fl({k[1], 3'h0, 2'b10, a, 8'h00}, {a[17], k[0] & ~k[1], a[15:0]});
    end
    complete_run();
  end
endmodule : ncsr_top_tb_top
bind ncsr_top ncsr_top_asserts i_ncsr_top_asserts (.sys_clk, .arst_n, .reg_addr, .reg_rd,
  .reg_rdata, .rx_desc_ptr_now, .flash_addr, .flash_dout_oe, .flash_ce_n, .flash_oe_n,
  .flash_we_n);
